// file: verilog/two_wire_control_register_map.sv
// two-wire serial slave in front of the control register map
module two_wire_control_register_map
	import two_wire_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic [9:0] monitor_result_i,
	output two_wire_pkg::settings_type settings_o
);
	import two_wire_pkg::*;

	// phases of one transfer, from start to stop
	// ADDR, REGADDR, WDATA shift bits in on rising edges
	// ACK pulls the line for one clock, RDATA shifts bits out
	// RACK hears the master's answer, DONE waits for stop
	typedef enum logic [2:0] {IDLE, ADDR, ACK, REGADDR, WDATA, RDATA, RACK, DONE} phase_type;

	// whole state of the serial engine in one record
	typedef struct packed {
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic scl_prev;
		logic sda_prev;
		phase_type phase;
		phase_type after_ack;
		logic [2:0] bit_count;
		logic byte_full;
		logic [7:0] shift;
		logic [3:0] reg_ptr;
		logic ptr_valid;
		logic drive_low;
		write_type wr;
	} state_type;

	// both lines seen high at reset, so no false edge follows
	localparam state_type STATE_RESET = '{
		scl_sync: 2'h3,
		sda_sync: 2'h3,
		scl_prev: 1'b1,
		sda_prev: 1'b1,
		phase: IDLE,
		after_ack: IDLE,
		bit_count: 3'h0,
		byte_full: 1'b0,
		shift: 8'h00,
		reg_ptr: 4'h0,
		ptr_valid: 1'b0,
		drive_low: 1'b0,
		wr: '{
			valid: 1'b0,
			addr: 4'h0,
			data: 8'h00
		}
	};

	// engine state and read path
	state_type state_reg;
	state_type state_next;
	logic [7:0] rd_data;
	logic [7:0] load_byte;

	// line levels and bus conditions
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	// next value of the bit counter inside a byte
	// wraps after the eighth bit, the flag marks the byte
	function automatic logic [2:0] count_up(input logic [2:0] c);
		count_up = c + 3'h1;
	endfunction : count_up

	// high when this rising edge carries the eighth bit
	// a plain zero count cannot tell a start from a full byte
	function automatic logic at_last(input logic [2:0] c);
		at_last = (c == BIT_LAST);
	endfunction : at_last

	// address byte names this device
	// direction bit is not part of the match
	function automatic logic addr_match(input logic [7:0] b);
		addr_match = (b[7:1] == DEVICE_ADDR);
	endfunction : addr_match

	// register address inside the sixteen-byte map
	// a wider address would alias into the map otherwise
	function automatic logic ptr_in_map(input logic [7:0] b);
		ptr_in_map = (b[7:4] == 4'h0);
	endfunction : ptr_in_map

	// byte to send for a read
	// outside the map the master reads zero
	function automatic logic [7:0] read_byte(input logic valid, input logic [7:0] d);
		read_byte = valid ? d : 8'h00;
	endfunction : read_byte

	// count one bit on a rising clock edge
	// the same count serves bytes in and bytes out
	function automatic state_type count_bit(input state_type s);
		state_type n;
		n = s;
		n.bit_count = count_up(s.bit_count);
		n.byte_full = at_last(s.bit_count);
		return n;
	endfunction : count_bit

	// sample one received bit, msb first
	// data is only read while the clock is high
	function automatic state_type take_bit(input state_type s, input logic d);
		state_type n;
		n = count_bit(s);
		n.shift = {s.shift[6:0], d};
		return n;
	endfunction : take_bit

	// received byte complete: decide on acknowledge and what follows
	function automatic state_type end_of_byte(input state_type s);
		state_type n;
		n = s;
		n.byte_full = 1'b0;
		n.phase = ACK;
		n.drive_low = 1'b1;
		unique case (s.phase)
			ADDR:
			begin
				if (!addr_match(s.shift))
				begin
					// foreign address: leave the line high, wait for stop
					n.phase = DONE;
					n.drive_low = 1'b0;
				end
				else if (s.shift[0])
				begin
					n.after_ack = RDATA;
				end
				else
				begin
					n.after_ack = REGADDR;
				end
			end
			REGADDR:
			begin
				n.reg_ptr = s.shift[3:0];
				n.ptr_valid = ptr_in_map(s.shift);
				n.after_ack = WDATA;
			end
			WDATA:
			begin
				// writes outside the map are dropped
				n.wr.valid = s.ptr_valid;
				n.wr.addr = s.reg_ptr;
				n.wr.data = s.shift;
				n.after_ack = DONE;
			end
			default:
			begin
				n.phase = DONE;
				n.drive_low = 1'b0;
			end
		endcase
		return n;
	endfunction : end_of_byte

	// acknowledge clock over: release, and load the byte for a read
	function automatic state_type end_of_ack(input state_type s, input logic [7:0] b);
		state_type n;
		n = s;
		n.phase = s.after_ack;
		n.bit_count = 3'h0;
		n.byte_full = 1'b0;
		n.drive_low = 1'b0;
		if (s.after_ack == RDATA)
		begin
			// first data bit goes out in the same low phase
			n.shift = b;
			n.drive_low = !b[7];
		end
		return n;
	endfunction : end_of_ack

	// next low phase of a read byte
	function automatic state_type send_step(input state_type s);
		state_type n;
		n = s;
		if (s.byte_full)
		begin
			// byte out: let the master answer on a free line
			n.byte_full = 1'b0;
			n.drive_low = 1'b0;
			n.phase = RACK;
		end
		else
		begin
			n.shift = {s.shift[6:0], 1'b0};
			n.drive_low = !s.shift[6];
		end
		return n;
	endfunction : send_step

	// byte registers and their field view
	register_map regs_u (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.wr_i(state_reg.wr),
		.rd_addr_i(state_reg.reg_ptr),
		.monitor_result_i(monitor_result_i),
		.rd_data_o(rd_data),
		.settings_o(settings_o)
	);

	// synchronised line levels; only the second flop is read
	assign scl = state_reg.scl_sync[1];
	assign sda = state_reg.sda_sync[1];

	// clock edges against the last cycle
	assign scl_rise = scl && !state_reg.scl_prev;
	assign scl_fall = !scl && state_reg.scl_prev;

	// data moving while the clock stays high
	assign start_seen = scl && state_reg.scl_prev && state_reg.sda_prev && !sda;
	assign stop_seen = scl && state_reg.scl_prev && !state_reg.sda_prev && sda;

	// byte a read returns at the current pointer
	assign load_byte = read_byte(state_reg.ptr_valid, rd_data);

	// protocol engine
	// the line only moves while the clock is low, so a
	// start or stop is never made by the device itself
	always_comb
	begin
		state_next = state_reg;
		state_next.scl_sync = {state_reg.scl_sync[0], scl_i};
		state_next.sda_sync = {state_reg.sda_sync[0], sda_i};
		state_next.scl_prev = scl;
		state_next.sda_prev = sda;
		state_next.wr.valid = 1'b0;
		if (stop_seen)
		begin
			// a stop ends the transfer in every phase
			state_next.phase = IDLE;
			state_next.drive_low = 1'b0;
		end
		else if (start_seen)
		begin
			// also a repeated start; register pointer is kept
			state_next.phase = ADDR;
			state_next.bit_count = 3'h0;
			state_next.byte_full = 1'b0;
			state_next.drive_low = 1'b0;
		end
		else
		begin
			unique case (state_reg.phase)
				IDLE, DONE:
				begin
					state_next.drive_low = 1'b0;
				end
				ADDR, REGADDR, WDATA:
				begin
					// bits in on rising edges, verdict after the eighth
					if (scl_rise)
					begin
						state_next = take_bit(state_next, sda);
					end
					else if (scl_fall && state_reg.byte_full)
					begin
						state_next = end_of_byte(state_next);
					end
				end
				ACK:
				begin
					// hold the pull until the clock falls again
					if (scl_fall)
					begin
						state_next = end_of_ack(state_next, load_byte);
					end
				end
				RDATA:
				begin
					// count on rising edges, move data on falling ones
					if (scl_rise)
					begin
						state_next = count_bit(state_next);
					end
					else if (scl_fall)
					begin
						state_next = send_step(state_next);
					end
				end
				RACK:
				begin
					// master's answer ends the single-byte read
					if (scl_rise)
					begin
						state_next.phase = DONE;
					end
				end
			endcase
		end
	end

	// state register, bus released at reset
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			state_reg <= STATE_RESET;
		else
			state_reg <= state_next;
	end

	// data level is always low: the pin only pulls
	assign sda_o = 1'b0;
	// enable low while pulling, straight from a flop
	assign sda_oe_n_o = !state_reg.drive_low;
endmodule : two_wire_control_register_map

// file: pkg/two_wire_pkg.sv
// constants and types of the two-wire control register map
package two_wire_pkg;
	localparam logic [6:0] DEVICE_ADDR = 7'h08;
	localparam logic [3:0] REG_CONTROL = 4'h0;
	localparam logic [3:0] REG_SWING = 4'h1;
	localparam logic [3:0] REG_PREEMPH = 4'h2;
	localparam logic [3:0] REG_EQ = 4'h3;
	localparam logic [3:0] REG_XPOINT = 4'h4;
	localparam logic [3:0] REG_XPOINT_AUX = 4'h5;
	localparam logic [3:0] REG_LIMITER = 4'h6;
	localparam logic [3:0] REG_BIAS_TRIM = 4'h7;
	localparam logic [3:0] REG_MONITOR_SETUP = 4'hD;
	localparam logic [3:0] REG_RESULT_HIGH = 4'hE;
	localparam logic [3:0] REG_RESULT_LOW = 4'hF;
	// writable bit masks, unused bits stay zero
	localparam logic [7:0] MASK_FULL = 8'hFF;
	localparam logic [7:0] MASK_PREEMPH = 8'h0F;
	localparam logic [7:0] MASK_XPOINT_AUX = 8'hEB;
	localparam logic [7:0] MASK_BIAS_TRIM = 8'hCF;
	localparam logic [7:0] MASK_MONITOR = 8'hC1;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic [2:0] BIT_LAST = 3'h7;
	typedef struct packed {
		logic chip_on;
		logic weak_pullup_select;
		logic preemph_on;
		logic preemph_high_range;
		logic crosspoint_adjust_on;
		logic output_invert;
		logic eq_on;
		logic swing_source_select;
	} control_type;
	typedef struct packed {
		control_type control;
		logic [7:0] swing_code;
		logic [3:0] preemph_level;
		logic [7:0] boost_code;
		logic crosspoint_sign;
		logic [6:0] crosspoint_magnitude;
		logic offset_range;
		logic [1:0] offset_shift;
		logic follower_range;
		logic [1:0] crosspoint_boost;
		logic limiter_bias_sign;
		logic [2:0] limiter_bias_level;
		logic follower_sign;
		logic [2:0] follower_level;
		logic bias_trim_up;
		logic bias_trim_down;
		logic bias_trim_sign;
		logic [2:0] bias_trim_follower;
		logic monitor_off;
		logic monitor_osc_off;
		logic monitor_select;
	} settings_type;
	typedef struct packed {
		logic valid;
		logic [3:0] addr;
		logic [7:0] data;
	} write_type;
endpackage : two_wire_pkg

// file: verilog/register_map.sv
// byte register file of the control map
module register_map
	import two_wire_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire two_wire_pkg::write_type wr_i,
	input wire logic [3:0] rd_addr_i,
	input wire logic [9:0] monitor_result_i,
	output logic [7:0] rd_data_o,
	output two_wire_pkg::settings_type settings_o
);
	import two_wire_pkg::*;

	logic [7:0] regs_reg [0:15];
	logic [7:0] regs_next [0:15];

	// writable mask per address
	function automatic logic [7:0] write_mask(input logic [3:0] a);
		unique case (a)
			REG_CONTROL, REG_SWING, REG_EQ, REG_XPOINT, REG_LIMITER: write_mask = MASK_FULL;
			REG_PREEMPH: write_mask = MASK_PREEMPH;
			REG_XPOINT_AUX: write_mask = MASK_XPOINT_AUX;
			REG_BIAS_TRIM: write_mask = MASK_BIAS_TRIM;
			REG_MONITOR_SETUP: write_mask = MASK_MONITOR;
			default: write_mask = 8'h00;
		endcase
	endfunction : write_mask

	// store masked write data
	always_comb
	begin
		regs_next = regs_reg;
		if (wr_i.valid)
			regs_next[wr_i.addr] = wr_i.data & write_mask(wr_i.addr);
	end

	// clear on reset
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			for (int i = 0; i < 16; i++)
				regs_reg[i] <= RESET_VALUE;
		end
		else
			regs_reg <= regs_next;
	end

	// read mux with result bytes
	always_comb
	begin
		unique case (rd_addr_i)
			REG_RESULT_HIGH: rd_data_o = monitor_result_i[9:2];
			REG_RESULT_LOW: rd_data_o = {6'h00, monitor_result_i[1:0]};
			default: rd_data_o = regs_reg[rd_addr_i];
		endcase
	end

	// field view of the control bytes
	assign settings_o.control = control_type'(regs_reg[REG_CONTROL]);
	assign settings_o.swing_code = regs_reg[REG_SWING];
	assign settings_o.preemph_level = regs_reg[REG_PREEMPH][3:0];
	assign settings_o.boost_code = regs_reg[REG_EQ];
	assign settings_o.crosspoint_sign = regs_reg[REG_XPOINT][7];
	assign settings_o.crosspoint_magnitude = regs_reg[REG_XPOINT][6:0];
	assign settings_o.offset_range = regs_reg[REG_XPOINT_AUX][7];
	assign settings_o.offset_shift = regs_reg[REG_XPOINT_AUX][6:5];
	assign settings_o.follower_range = regs_reg[REG_XPOINT_AUX][3];
	assign settings_o.crosspoint_boost = regs_reg[REG_XPOINT_AUX][1:0];
	assign settings_o.limiter_bias_sign = regs_reg[REG_LIMITER][7];
	assign settings_o.limiter_bias_level = regs_reg[REG_LIMITER][6:4];
	assign settings_o.follower_sign = regs_reg[REG_LIMITER][3];
	assign settings_o.follower_level = regs_reg[REG_LIMITER][2:0];
	assign settings_o.bias_trim_up = regs_reg[REG_BIAS_TRIM][7];
	assign settings_o.bias_trim_down = regs_reg[REG_BIAS_TRIM][6];
	assign settings_o.bias_trim_sign = regs_reg[REG_BIAS_TRIM][3];
	assign settings_o.bias_trim_follower = regs_reg[REG_BIAS_TRIM][2:0];
	assign settings_o.monitor_off = regs_reg[REG_MONITOR_SETUP][7];
	assign settings_o.monitor_osc_off = regs_reg[REG_MONITOR_SETUP][6];
	assign settings_o.monitor_select = regs_reg[REG_MONITOR_SETUP][0];
endmodule : register_map

// file: verif/two_wire_master.sv
// two-wire bus master model on an open-drain data line
module two_wire_master
(
	input wire logic clk_i,
	input wire logic sda_oe_n_i,
	output logic scl_o,
	output logic sda_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drv = 1'b1;
	initial scl_o = 1'b1;
	// wired-and over the pull-up
	assign sda_o = drv & sda_oe_n_i;
	// quarter bit of four cycles, then move both pins
	task automatic step(input logic s, input logic d);
		repeat (4) @(posedge clk_i);
		#1 scl_o = s;
		drv = d;
	endtask : step
	// data a set while scl low, b late in the high phase: start, stop or plain bit
	task automatic bit_io(input logic a, input logic b, output logic r);
		step(1'b0, drv);
		step(1'b0, a);
		step(1'b1, a);
		r = sda_o;
		step(1'b1, b);
	endtask : bit_io
	// msb first, then the ninth bit released and read back
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ak);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], tx[i], rx[i]);
		bit_io(1'b1, 1'b1, ak);
	endtask : xfer
endmodule : two_wire_master

// file: verif/two_wire_control_register_map_chk.sv
// port assertions of the two-wire register map
module two_wire_control_register_map_chk
	import two_wire_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire two_wire_pkg::settings_type settings_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	int age;
	int lo;
	// cycles since the last pull, and length of this pull
	always_ff @(posedge clk_i or negedge arst_n_i)
		age <= !arst_n_i ? 999 : (!sda_oe_n_o ? 0 : (age < 999 ? age + 1 : age));
	always_ff @(posedge clk_i or negedge arst_n_i)
		lo <= !arst_n_i ? 0 : (!sda_oe_n_o ? lo + 1 : 0);
	property p_low; sda_o == 1'b0; endproperty
	a_low: assert property (p_low) else $error("sda driven high");
	property p_clr; $rose(arst_n_i) |-> settings_o == '0; endproperty
	a_clr: assert property (p_clr) else $error("not cleared");
	property p_rel; $rose(arst_n_i) |-> sda_oe_n_o [*8]; endproperty
	a_rel: assert property (p_rel) else $error("not released");
	property p_edge; $changed(sda_oe_n_o) |-> !scl_i; endproperty
	a_edge: assert property (p_edge) else $error("moved, scl high");
	property p_hold; $fell(sda_oe_n_o) |-> !sda_oe_n_o [*8]; endproperty
	a_hold: assert property (p_hold) else $error("pull too short");
	property p_span; lo < 170; endproperty
	a_span: assert property (p_span) else $error("pull too long");
	property p_wr; $changed(settings_o) |-> age < 200; endproperty
	a_wr: assert property (p_wr) else $error("write, no ack");
	property p_sta; scl_i && $fell(sda_i) |-> sda_oe_n_o; endproperty
	a_sta: assert property (p_sta) else $error("pull at start");
endmodule : two_wire_control_register_map_chk

// file: verif/test_two_wire_control_register_map.sv
// self-checking bench of the two-wire register map
module test_two_wire_control_register_map;
	timeunit 1ns;
	timeprecision 1ps;
	import two_wire_pkg::*;
	localparam logic [7:0] DEV = {DEVICE_ADDR, 1'b0};
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic scl_i, sda_i, sda_o, sda_oe_n_o, x;
	logic [9:0] monitor_result_i = 10'h2B5;
	logic [7:0] q;
	logic [3:0] ak;
	settings_type settings_o;
	int bad_count = 0, cmp_count = 0, cycles = 0;
	// register, value written, value read back
	logic [23:0] rows [13] = '{24'h00A5A5, 24'h015A5A, 24'h02FF0F, 24'h03C3C3, 24'h049696, 24'h05FFEB,
		24'h066969, 24'h07FFCF, 24'h08FF00, 24'h0CFF00, 24'h0DFFC1, 24'h0EFFAD, 24'h0FFF01};
`define CHECK_EQ(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
	always #4 clk_i = ~clk_i;
	two_wire_master mst_u (.clk_i, .sda_oe_n_i(sda_oe_n_o), .scl_o(scl_i), .sda_o(sda_i));
	two_wire_control_register_map dut_u (.clk_i, .arst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o,
		.monitor_result_i, .settings_o);
	// one transfer; ak holds its ninth bits, ak[1] only for a read and left at zero for a write
	task automatic acc(input logic [7:0] d, input logic [7:0] a, input logic [7:0] w, input logic r);
		ak = 4'h0;
		mst_u.bit_io(1'b1, 1'b0, x);
		mst_u.xfer(d, q, ak[3]);
		mst_u.xfer(a, q, ak[2]);
		if (r)
		begin
			mst_u.bit_io(1'b1, 1'b0, x);
			mst_u.xfer(d | 8'h01, q, ak[1]);
		end
		mst_u.xfer(r ? 8'hFF : w, q, ak[0]);
		mst_u.bit_io(1'b0, 1'b1, x);
	endtask : acc
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	// cut a hang short
	always @(posedge clk_i)
		if (++cycles == 40000)
		begin
			bad_count++;
			test_done();
		end
	// reset, table of writes and reads, then the awkward cases
	initial
	begin
		repeat (2) @(posedge clk_i);
		#1 arst_n_i = 1'b1;
		`CHECK_EQ("reset", 59'h0, settings_o)
		foreach (rows[i])
		begin
			acc(DEV, rows[i][23:16], rows[i][15:8], 1'b0);
			`CHECK_EQ("acks", 4'h0, ak)
			acc(DEV, rows[i][23:16], 8'h00, 1'b1);
			`CHECK_EQ("read", {4'h1, rows[i][7:0]}, {ak, q})
		end
		`CHECK_EQ("fields", {8'hA5, 8'h5A, 4'hF, 8'hC3, 8'h96, 6'h3F, 8'h69, 6'h3F, 3'h7}, settings_o)
		acc(8'h12, 8'h01, 8'h00, 1'b0);
		`CHECK_EQ("other", {4'hD, 8'h5A}, {ak, settings_o.swing_code})
		monitor_result_i = 10'h14A;
		acc(DEV, 8'h0E, 8'h00, 1'b1);
		`CHECK_EQ("result", 8'h52, q)
		acc(DEV, 8'h0F, 8'h00, 1'b1);
		`CHECK_EQ("result low", 8'h02, q)
		// address beyond the map must not alias onto its low nibble
		acc(DEV, 8'h21, 8'hFF, 1'b0);
		`CHECK_EQ("outside", 8'h5A, settings_o.swing_code)
		acc(DEV, 8'h21, 8'h00, 1'b1);
		`CHECK_EQ("outside read", {4'h1, 8'h00}, {ak, q})
		// reset in mid-run: map cleared, line released
		@(posedge clk_i);
		#1 arst_n_i = 1'b0;
		@(posedge clk_i);
		#1 `CHECK_EQ("mid reset", {1'b1, 59'h0}, {sda_oe_n_o, settings_o})
		arst_n_i = 1'b1;
		acc(DEV, 8'h01, 8'h00, 1'b1);
		`CHECK_EQ("after reset", {4'h1, 8'h00}, {ak, q})
		test_done();
	end
endmodule : test_two_wire_control_register_map
bind two_wire_control_register_map two_wire_control_register_map_chk chk_u (.clk_i, .arst_n_i, .scl_i, .sda_i,
	.sda_o, .sda_oe_n_o, .settings_o);
